/* File: include/stcd_defs.svh */
/*
 target command decoder constants: command codes, field positions, counter widths.
 included by the decoder only; holds definitions only.
*/
`ifndef STCD_DEFS_SVH
`define STCD_DEFS_SVH

`define STCD_GRP_HI        7
`define STCD_GRP_LO        5
`define STCD_GRP_TARGET    3'h1
`define STCD_DISC_BIT      4
`define STCD_CODE_RESEL1   8'h20
`define STCD_CODE_RESELN   8'h21
`define STCD_CODE_RS1_TERM 8'h22
`define STCD_CODE_RS1_LINK 8'h23
`define STCD_CODE_TERM     8'h24
`define STCD_CODE_LINK     8'h25
`define STCD_CODE_DISC_SEQ 8'h26
`define STCD_CODE_SEND_NM  8'h27
`define STCD_CODE_RECV_NC  8'h28
`define STCD_CODE_RECV_NM  8'h29
`define STCD_CODE_RSN_TERM 8'h2a
`define STCD_CODE_RSN_LINK 8'h2b
`define STCD_CODE_DISC2    8'h2c
`define STCD_CODE_RESEL    8'h30
`define STCD_CODE_SET_REQ  8'h31
`define STCD_CODE_CLR_REQ  8'h32
`define STCD_CODE_DISCON   8'h33
`define STCD_CODE_SEND_HST 8'h34
`define STCD_CODE_SEND_DMA 8'h35
`define STCD_CODE_RECV_HST 8'h36
`define STCD_CODE_RECV_DMA 8'h37
`define STCD_CODE_SEND_MSG 8'h38
`define STCD_CODE_RECV_MSG 8'h39
`define STCD_CODE_SEND_STS 8'h3a
`define STCD_CODE_RECV_CDB 8'h3b
`define STCD_CODE_CHN_HST  8'h3e
`define STCD_CODE_CHN_DMA  8'h3f
`define STCD_BLK_W         16
`define STCD_BYTE_W        16
`define STCD_PAD_BYTE      8'h00

`endif

/* File: include/stcd_pkg.sv */
/*
 types of the target command decoder: bus actions and the step sequencer states.
 assumes stcd_defs.svh is on the include path.
*/
package stcd_pkg;
   typedef enum logic [3:0] {
      STCD_ACT_NONE,
      STCD_ACT_RESELECT,
      STCD_ACT_MSG_IN,
      STCD_ACT_MSG_OUT,
      STCD_ACT_STATUS,
      STCD_ACT_CMD_IN,
      STCD_ACT_DATA,
      STCD_ACT_TERMINATE,
      STCD_ACT_LINK_TERM,
      STCD_ACT_DISCONNECT,
      STCD_ACT_SET_REQ,
      STCD_ACT_CLR_REQ
   } stcd_act_e;

   typedef enum logic [2:0] {
      STCD_IDLE,
      STCD_STEP,
      STCD_XFER,
      STCD_PAD
   } stcd_state_e;
endpackage

/* File: logic/stcd_decoder.sv */
/*
 target command decoder: decodes 8-bit target codes 20h-3fh into a sequence of bus
 actions, runs data transfers with zero padding and chained sends.
 assumes a bus engine that performs each action (act_valid/act_done) and moves bytes
 (byte_stb); phase change arrives as an asynchronous level and is synchronised here.
*/
// Notes on behaviour
// - padding starts once moved bytes equal programmed block and byte count
// - synchronous input padding may leave data-register empty indication clear
// - zero block and byte counts start padding at the first byte
// - zero-count padding keeps block, byte and modified-byte counters unchanged
// - padding continues until the target changes bus phase
// - chained data commands exist only for sending
// - odd chained send holds last byte for the next transfer's first byte
// - 22h: reselect, one message, terminate; 23h: same with linked termination
// - 2ah: reselect, multi-byte message, terminate
// - 2bh: reselect, multi-byte message, linked termination
// - 38h sends one message; operand locates the message byte
// - 39h receives one message; operand locates its store
// - 3ah sends one status byte; operand locates the status value
// - 3bh receives a command block; operand locates its store
// - 3eh chained send from host processor; operand points to count
// - 3fh chained send via dma; operand points to count and address
// - padding drives zero bytes when sending, discards bytes when receiving
`timescale 1ns/1ps
`include "stcd_defs.svh"

module stcd_decoder #(
   parameter int BLK_W  = `STCD_BLK_W,
   parameter int BYTE_W = `STCD_BYTE_W
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire logic                cmd_valid,
   output logic                     cmd_ready,
   input  wire logic [7:0]          cmd_code,
   input  wire logic [15:0]         cmd_operand,
   input  wire logic                user_program,
   output logic                     cmd_reserved,
   output logic                     cmd_done,
   input  wire logic [BLK_W-1:0]    blk_count,
   input  wire logic [BYTE_W-1:0]   byte_count,
   output logic                     act_valid,
   output stcd_pkg::stcd_act_e      act_kind,
   input  wire logic                act_done,
   output logic [15:0]              operand_addr,
   output logic                     operand_valid,
   output logic                     xfer_send,
   output logic                     xfer_dma,
   output logic                     xfer_chain,
   output logic                     xfer_padding,
   input  wire logic                phase_change,
   input  wire logic                byte_stb,
   input  wire logic [7:0]          host_byte,
   output logic [7:0]               bus_byte,
   input  wire logic [7:0]          bus_in_byte,
   output logic                     rx_store,
   output logic [7:0]               rx_byte,
   output logic [BLK_W-1:0]         blk_left,
   output logic [BYTE_W-1:0]        byte_left,
   output logic [BYTE_W-1:0]        mod_bytes,
   output logic                     held_valid,
   output logic                     empty_flag_hold
);
   localparam int NSTEP = 3;

   stcd_pkg::stcd_state_e          state_r;
   stcd_pkg::stcd_act_e            steps_r [NSTEP];
   logic [1:0]                     step_idx_r;
   logic                           has_xfer_r;
   logic                           pad_en_r;
   logic                           ph_meta_r;
   logic                           ph_sync_r;
   logic                           ph_prev_r;
   logic                           ph_edge;
   logic [7:0]                     held_byte_r;
   logic                           odd_r;
   logic                           last_byte;
   stcd_pkg::stcd_act_e            dec_steps [NSTEP];
   logic                           dec_xfer;
   logic                           dec_send;
   logic                           dec_dma;
   logic                           dec_chain;
   logic                           dec_pad;
   logic                           dec_rsv;
   logic                           dec_opnd;

   // phase change pin is asynchronous; the edge is taken from the second and third stages
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ph_meta_r <= 1'b0;
         ph_sync_r <= 1'b0;
         ph_prev_r <= 1'b0;
      end else begin
         ph_meta_r <= phase_change;
         ph_sync_r <= ph_meta_r;
         ph_prev_r <= ph_sync_r;
      end
   end
   assign ph_edge = ph_sync_r & ~ph_prev_r;

   always_comb begin
      for (int i = 0; i < NSTEP; i++) begin
         dec_steps[i] = stcd_pkg::STCD_ACT_NONE;
      end
      dec_xfer  = 1'b0;
      dec_send  = 1'b0;
      dec_dma   = 1'b0;
      dec_chain = 1'b0;
      dec_pad   = 1'b0;
      dec_rsv   = 1'b0;
      dec_opnd  = 1'b0;
      if (cmd_code[`STCD_GRP_HI:`STCD_GRP_LO] != `STCD_GRP_TARGET) begin
         dec_rsv = 1'b1;
      end else if (!cmd_code[`STCD_DISC_BIT]) begin
         case (cmd_code)
            `STCD_CODE_RESEL1, `STCD_CODE_RESELN: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_RESELECT;
               dec_steps[1] = stcd_pkg::STCD_ACT_MSG_IN;
            end
            `STCD_CODE_RS1_TERM, `STCD_CODE_RSN_TERM: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_RESELECT;
               dec_steps[1] = stcd_pkg::STCD_ACT_MSG_IN;
               dec_steps[2] = stcd_pkg::STCD_ACT_TERMINATE;
            end
            `STCD_CODE_RS1_LINK, `STCD_CODE_RSN_LINK: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_RESELECT;
               dec_steps[1] = stcd_pkg::STCD_ACT_MSG_IN;
               dec_steps[2] = stcd_pkg::STCD_ACT_LINK_TERM;
            end
            `STCD_CODE_TERM:     dec_steps[0] = stcd_pkg::STCD_ACT_TERMINATE;
            `STCD_CODE_LINK:     dec_steps[0] = stcd_pkg::STCD_ACT_LINK_TERM;
            `STCD_CODE_DISC_SEQ, `STCD_CODE_DISC2: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_MSG_IN;
               dec_steps[1] = stcd_pkg::STCD_ACT_DISCONNECT;
            end
            `STCD_CODE_SEND_NM:  dec_steps[0] = stcd_pkg::STCD_ACT_MSG_IN;
            `STCD_CODE_RECV_NC:  dec_steps[0] = stcd_pkg::STCD_ACT_CMD_IN;
            `STCD_CODE_RECV_NM:  dec_steps[0] = stcd_pkg::STCD_ACT_MSG_OUT;
            default:             dec_rsv = 1'b1;
         endcase
      end else begin
         case (cmd_code)
            `STCD_CODE_RESEL:    dec_steps[0] = stcd_pkg::STCD_ACT_RESELECT;
            `STCD_CODE_SET_REQ:  dec_steps[0] = stcd_pkg::STCD_ACT_SET_REQ;
            `STCD_CODE_CLR_REQ:  dec_steps[0] = stcd_pkg::STCD_ACT_CLR_REQ;
            `STCD_CODE_DISCON:   dec_steps[0] = stcd_pkg::STCD_ACT_DISCONNECT;
            `STCD_CODE_SEND_MSG: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_MSG_IN;
               dec_opnd     = 1'b1;
            end
            `STCD_CODE_RECV_MSG: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_MSG_OUT;
               dec_opnd     = 1'b1;
            end
            `STCD_CODE_SEND_STS: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_STATUS;
               dec_opnd     = 1'b1;
            end
            `STCD_CODE_RECV_CDB: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_CMD_IN;
               dec_opnd     = 1'b1;
            end
            `STCD_CODE_SEND_HST, `STCD_CODE_SEND_DMA, `STCD_CODE_RECV_HST, `STCD_CODE_RECV_DMA,
            `STCD_CODE_CHN_HST, `STCD_CODE_CHN_DMA: begin
               dec_steps[0] = stcd_pkg::STCD_ACT_DATA;
               dec_xfer     = 1'b1;
               dec_opnd     = 1'b1;
               dec_dma      = cmd_code[0];
               dec_send     = ~cmd_code[1] | cmd_code[3];
               dec_chain    = cmd_code[3];
               dec_pad      = ~cmd_code[3];
            end
            default:             dec_rsv = 1'b1;
         endcase
      end
   end

   assign cmd_ready = (state_r == stcd_pkg::STCD_IDLE);
   assign act_valid = (state_r == stcd_pkg::STCD_STEP);
   assign act_kind  = steps_r[step_idx_r];
   assign last_byte = (blk_left == '0) && (byte_left == BYTE_W'(1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r       <= stcd_pkg::STCD_IDLE;
         step_idx_r    <= 2'h0;
         has_xfer_r    <= 1'b0;
         pad_en_r      <= 1'b0;
         cmd_done      <= 1'b0;
         cmd_reserved  <= 1'b0;
         operand_addr  <= 16'h0000;
         operand_valid <= 1'b0;
         xfer_send     <= 1'b0;
         xfer_dma      <= 1'b0;
         xfer_chain    <= 1'b0;
         xfer_padding  <= 1'b0;
         for (int i = 0; i < NSTEP; i++) begin
            steps_r[i] <= stcd_pkg::STCD_ACT_NONE;
         end
      end else begin
         cmd_done     <= 1'b0;
         cmd_reserved <= 1'b0;
         case (state_r)
            stcd_pkg::STCD_IDLE: begin
               if (cmd_valid) begin
                  if (dec_rsv) begin
                     cmd_reserved <= 1'b1;
                     cmd_done     <= 1'b1;
                  end else begin
                     steps_r       <= dec_steps;
                     step_idx_r    <= 2'h0;
                     has_xfer_r    <= dec_xfer;
                     pad_en_r      <= dec_pad;
                     xfer_send     <= dec_send;
                     xfer_dma      <= dec_dma;
                     xfer_chain    <= dec_chain;
                     operand_addr  <= cmd_operand;
                     operand_valid <= dec_opnd & user_program;
                     state_r       <= stcd_pkg::STCD_STEP;
                  end
               end
            end
            stcd_pkg::STCD_STEP: begin
               if (act_done) begin
                  if (has_xfer_r) begin
                     if ((blk_count == '0) && (byte_count == '0)) begin
                        xfer_padding <= pad_en_r;
                        state_r      <= pad_en_r ? stcd_pkg::STCD_PAD : stcd_pkg::STCD_IDLE;
                        cmd_done     <= ~pad_en_r;
                     end else begin
                        state_r <= stcd_pkg::STCD_XFER;
                     end
                  end else if (step_idx_r == 2'(NSTEP - 1) || steps_r[step_idx_r + 2'h1] == stcd_pkg::STCD_ACT_NONE) begin
                     state_r       <= stcd_pkg::STCD_IDLE;
                     cmd_done      <= 1'b1;
                     operand_valid <= 1'b0;
                  end else begin
                     step_idx_r <= step_idx_r + 2'h1;
                  end
               end
            end
            stcd_pkg::STCD_XFER: begin
               if (ph_edge) begin
                  state_r  <= stcd_pkg::STCD_IDLE;
                  cmd_done <= 1'b1;
               end else if (byte_stb && last_byte) begin
                  xfer_padding <= pad_en_r;
                  state_r      <= pad_en_r ? stcd_pkg::STCD_PAD : stcd_pkg::STCD_IDLE;
                  cmd_done     <= ~pad_en_r;
               end
            end
            stcd_pkg::STCD_PAD: begin
               if (ph_edge) begin
                  xfer_padding  <= 1'b0;
                  operand_valid <= 1'b0;
                  state_r       <= stcd_pkg::STCD_IDLE;
                  cmd_done      <= 1'b1;
               end
            end
            default: state_r <= stcd_pkg::STCD_IDLE;
         endcase
      end
   end

   // counters load at the data step; zero-start padding leaves them untouched
   // odd_r restarts per command: mod_bytes runs on, so its parity cannot mark an odd count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         blk_left  <= '0;
         byte_left <= '0;
         mod_bytes <= '0;
         odd_r     <= 1'b0;
      end else if (state_r == stcd_pkg::STCD_STEP && act_done && has_xfer_r) begin
         blk_left  <= blk_count;
         byte_left <= byte_count;
         odd_r     <= 1'b0;
      end else if (state_r == stcd_pkg::STCD_XFER && byte_stb && !ph_edge) begin
         mod_bytes <= mod_bytes + BYTE_W'(1);
         odd_r     <= ~odd_r;
         if (byte_left == '0) begin
            blk_left  <= blk_left - BLK_W'(1);
            byte_left <= '1;
         end else begin
            byte_left <= byte_left - BYTE_W'(1);
         end
      end
   end

   // chained send: odd last byte is retained and leads the next transfer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         held_valid  <= 1'b0;
         held_byte_r <= 8'h00;
      end else if (state_r == stcd_pkg::STCD_XFER && byte_stb && last_byte && xfer_chain
                   && !odd_r) begin
         held_valid  <= 1'b1;
         held_byte_r <= host_byte;
      end else if (state_r == stcd_pkg::STCD_XFER && byte_stb && held_valid) begin
         held_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_byte        <= 8'h00;
         rx_store        <= 1'b0;
         rx_byte         <= 8'h00;
         empty_flag_hold <= 1'b0;
      end else begin
         rx_store <= 1'b0;
         if (state_r == stcd_pkg::STCD_PAD) begin
            bus_byte        <= `STCD_PAD_BYTE;
            empty_flag_hold <= ~xfer_send & byte_stb | empty_flag_hold;
         end else begin
            empty_flag_hold <= 1'b0;
            if (state_r == stcd_pkg::STCD_XFER && byte_stb) begin
               bus_byte <= held_valid ? held_byte_r : host_byte;
               rx_store <= ~xfer_send;
               rx_byte  <= bus_in_byte;
            end
         end
      end
   end
endmodule

/* File: tb/stcd_bus_engine.sv */
/*
 bus engine model: completes each requested action after lat cycles.
 drives act_done on the falling edge as a one-cycle pulse.
*/
`timescale 1ns/1ps
module stcd_bus_engine (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       act_valid,
   input  wire logic [3:0] lat,
   output logic            act_done
);
   int wait_cnt;
   always @(negedge clk or negedge resetn) begin
      if (!resetn) begin
         act_done <= 1'b0;
         wait_cnt <= 0;
      end else if (act_done || !act_valid) begin
         act_done <= 1'b0;
         wait_cnt <= 0;
      end else if (wait_cnt >= lat) begin
         act_done <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

/* File: tb/stcd_checker.sv */
/*
 port assertions of the target command decoder.
 bound to stcd_decoder from the testbench top; sees only its ports.
*/
`timescale 1ns/1ps
module stcd_checker (
   input wire logic                clk,
   input wire logic                resetn,
   input wire logic                cmd_valid,
   input wire logic                cmd_ready,
   input wire logic [7:0]          cmd_code,
   input wire logic [15:0]         cmd_operand,
   input wire logic                user_program,
   input wire logic                cmd_reserved,
   input wire logic                cmd_done,
   input wire logic                act_valid,
   input wire stcd_pkg::stcd_act_e act_kind,
   input wire logic                act_done,
   input wire logic [15:0]         operand_addr,
   input wire logic                operand_valid,
   input wire logic                xfer_send,
   input wire logic                xfer_chain,
   input wire logic                xfer_padding,
   input wire logic                phase_change,
   input wire logic [7:0]          bus_byte,
   input wire logic                rx_store
);
   logic tk;
   logic rsv;
   logic opnd;
   assign tk = cmd_valid && cmd_ready;
   assign rsv = cmd_code[7:5] != 3'h1 || cmd_code inside {8'h2d, 8'h2e, 8'h2f, 8'h3c, 8'h3d};
   assign opnd = cmd_code inside {[8'h34:8'h3b], 8'h3e, 8'h3f};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_reserved_answer: assert property (tk && rsv |=> cmd_reserved && cmd_done)
      else $error("reserved code not answered");
   a_reserved_quiet: assert property (tk && rsv |=> !act_valid)
      else $error("reserved code started an action");
   a_target_acts: assert property (tk && !rsv |=> act_valid && !cmd_ready)
      else $error("target code did not start an action");
   a_act_steady: assert property (act_valid && !act_done |=> act_valid && $stable(act_kind))
      else $error("action request dropped or changed");
   a_operand_out: assert property (tk && user_program && opnd |=> operand_valid && operand_addr == $past(cmd_operand))
      else $error("operand address not presented");
   a_pad_zero: assert property ($past(xfer_padding) && xfer_padding && xfer_send |-> bus_byte == 8'h00)
      else $error("padding byte not zero");
   a_pad_discard: assert property ($past(xfer_padding) && xfer_padding && !xfer_send |-> !rx_store)
      else $error("byte stored during padding");
   a_pad_hold: assert property ($fell(xfer_padding) |-> $past(phase_change, 2) || $past(phase_change, 3))
      else $error("padding ended without phase change");
   a_chain_send: assert property (xfer_chain |-> xfer_send)
      else $error("chained transfer not a send");
endmodule

/* File: tb/stcd_decoder_test.sv */
/*
 testbench of the target command decoder: action lists, reserved codes, operands, padding, chains.
 assumes stcd_bus_engine answers actions; bytes and phase change come from the bench.
*/
`timescale 1ns/1ps
module stcd_decoder_test;
   logic                clk, resetn, cmd_valid, cmd_ready, user_program, cmd_reserved, cmd_done;
   logic                act_valid, act_done, operand_valid, xfer_send, xfer_dma, xfer_chain;
   logic                xfer_padding, phase_change, byte_stb, rx_store, held_valid, empty_flag_hold;
   logic [3:0]          lat;
   logic [7:0]          cmd_code, host_byte, bus_byte, bus_in_byte, rx_byte;
   logic [15:0]         cmd_operand, operand_addr, blk_count, byte_count, blk_left, byte_left, mod_bytes;
   logic [15:0]         k_blk, k_byte, k_mod;
   stcd_pkg::stcd_act_e act_kind;
   stcd_pkg::stcd_act_e acts[$];
   int                  miscompares = 0;
   int                  checked = 0;

   stcd_decoder i_dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_code(cmd_code), .cmd_operand(cmd_operand), .user_program(user_program),
      .cmd_reserved(cmd_reserved), .cmd_done(cmd_done), .blk_count(blk_count), .byte_count(byte_count),
      .act_valid(act_valid), .act_kind(act_kind), .act_done(act_done), .operand_addr(operand_addr),
      .operand_valid(operand_valid), .xfer_send(xfer_send), .xfer_dma(xfer_dma), .xfer_chain(xfer_chain),
      .xfer_padding(xfer_padding), .phase_change(phase_change), .byte_stb(byte_stb),
      .host_byte(host_byte), .bus_byte(bus_byte), .bus_in_byte(bus_in_byte), .rx_store(rx_store),
      .rx_byte(rx_byte), .blk_left(blk_left), .byte_left(byte_left), .mod_bytes(mod_bytes),
      .held_valid(held_valid), .empty_flag_hold(empty_flag_hold));
   stcd_bus_engine i_eng (.clk(clk), .resetn(resetn), .act_valid(act_valid), .lat(lat), .act_done(act_done));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (act_valid && act_done)
         acts.push_back(act_kind);
   end

   task automatic end_sim;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_for(input string what, ref logic flag);
      int n;
      n = 0;
      while (flag !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) begin
         check(what, 16'h0, 16'h1);
         end_sim();
      end
   endtask
   task automatic issue(input logic [7:0] code, input logic up);
      wait_for("cmd_ready", cmd_ready);
      acts.delete();
      cmd_code = code;
      cmd_operand = {8'h5a, code};
      user_program = up;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask
   task automatic finish_cmd;
      wait_for("cmd_done", cmd_done);
      @(negedge clk);
   endtask
   task automatic start_data(input logic [7:0] code, input logic [15:0] cnt);
      int n;
      blk_count = 16'h0000;
      byte_count = cnt;
      issue(code, 1'b1);
      for (n = 0; n < 200 && acts.size() == 0; n++)
         @(negedge clk);
      if (n >= 200) begin
         check("data step", 16'h0, 16'h1);
         end_sim();
      end
      @(negedge clk);
   endtask
   task automatic strobe(input int cnt, input logic [7:0] d);
      for (int i = 0; i < cnt; i++) begin
         if (i > 0)
            @(negedge clk);
         host_byte = d + i[7:0];
         bus_in_byte = d + i[7:0];
         byte_stb = 1'b1;
         @(negedge clk);
         byte_stb = 1'b0;
         bus_in_byte = ~bus_in_byte;
      end
   endtask
   task automatic phase_end;
      phase_change = 1'b1;
      finish_cmd();
      phase_change = 1'b0;
      check("xfer_padding off", xfer_padding, 1'b0);
   endtask
   task automatic run_seq(input logic [7:0] code, input stcd_pkg::stcd_act_e last);
      issue(code, 1'b0);
      finish_cmd();
      check("action count", acts.size(), 16'h3);
      check("first action", acts[0], stcd_pkg::STCD_ACT_RESELECT);
      check("message action", acts[1], stcd_pkg::STCD_ACT_MSG_IN);
      check("last action", acts[2], last);
   endtask

   task automatic t_seq;
      lat = 4'h3;
      run_seq(8'h22, stcd_pkg::STCD_ACT_TERMINATE);
      run_seq(8'h23, stcd_pkg::STCD_ACT_LINK_TERM);
      lat = 4'h0;
      run_seq(8'h2a, stcd_pkg::STCD_ACT_TERMINATE);
      run_seq(8'h2b, stcd_pkg::STCD_ACT_LINK_TERM);
      $display("test sequences done");
   endtask
   task automatic t_reserved;
      logic [7:0] codes[9] = '{8'h2d, 8'h2e, 8'h2f, 8'h3c, 8'h3d, 8'h00, 8'h1f, 8'h40, 8'hc0};
      foreach (codes[i]) begin
         issue(codes[i], 1'b1);
         check("cmd_reserved", cmd_reserved, 1'b1);
         check("cmd_done", cmd_done, 1'b1);
         @(negedge clk);
      end
      $display("test reserved done");
   endtask
   task automatic t_discrete;
      stcd_pkg::stcd_act_e kinds[4] = '{stcd_pkg::STCD_ACT_MSG_IN, stcd_pkg::STCD_ACT_MSG_OUT,
         stcd_pkg::STCD_ACT_STATUS, stcd_pkg::STCD_ACT_CMD_IN};
      foreach (kinds[i]) begin
         issue(8'h38 + i[7:0], 1'b1);
         @(negedge clk);
         check("operand_addr", operand_addr, {8'h5a, 8'h38 + i[7:0]});
         finish_cmd();
         check("discrete action", acts[0], kinds[i]);
      end
      issue(8'h3a, 1'b0);
      @(negedge clk);
      check("operand_valid", operand_valid, 1'b0);
      finish_cmd();
      $display("test discrete done");
   endtask
   task automatic t_pad_send;
      lat = 4'h2;
      start_data(8'h34, 16'h0003);
      check("pad early", xfer_padding, 1'b0);
      strobe(3, 8'h81);
      check("pad start", xfer_padding, 1'b1);
      check("last data", bus_byte, 8'h83);
      strobe(2, 8'h91);
      check("pad byte", bus_byte, 8'h00);
      check("pad hold", xfer_padding, 1'b1);
      phase_end();
      $display("test pad send done");
   endtask
   task automatic t_pad_zero;
      start_data(8'h37, 16'h0000);
      check("zero pad", xfer_padding, 1'b1);
      k_blk = blk_left;
      k_byte = byte_left;
      k_mod = mod_bytes;
      strobe(3, 8'h41);
      check("blk_left", blk_left, k_blk);
      check("byte_left", byte_left, k_byte);
      check("mod_bytes", mod_bytes, k_mod);
      check("empty hold", empty_flag_hold, 1'b1);
      phase_end();
      start_data(8'h36, 16'h0001);
      strobe(1, 8'h55);
      check("rx_store", rx_store, 1'b1);
      check("rx_byte", rx_byte, 8'h55);
      strobe(1, 8'h66);
      check("rx discard", rx_byte, 8'h55);
      phase_end();
      $display("test pad zero done");
   endtask
   task automatic t_chain;
      start_data(8'h3f, 16'h0002);
      check("dma chain", {xfer_chain, xfer_dma}, 2'h3);
      strobe(2, 8'h11);
      finish_cmd();
      check("even held", held_valid, 1'b0);
      start_data(8'h3e, 16'h0003);
      check("host chain", {xfer_chain, xfer_dma}, 2'h2);
      strobe(3, 8'h21);
      finish_cmd();
      check("odd held", held_valid, 1'b1);
      start_data(8'h34, 16'h0001);
      check("last plain", xfer_chain, 1'b0);
      strobe(1, 8'h31);
      check("held first", bus_byte, 8'h23);
      phase_end();
      $display("test chain done");
   endtask

   initial begin
      {resetn, cmd_valid, user_program, phase_change, byte_stb} = 5'h00;
      lat = 4'h0;
      cmd_code = 8'h00;
      cmd_operand = 16'h0000;
      blk_count = 16'h0000;
      byte_count = 16'h0000;
      host_byte = 8'h00;
      bus_in_byte = 8'hff;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      t_seq();
      t_reserved();
      t_discrete();
      t_pad_send();
      t_pad_zero();
      t_chain();
      end_sim();
   end
endmodule

bind stcd_decoder stcd_checker i_chk (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_operand(cmd_operand), .user_program(user_program),
   .cmd_reserved(cmd_reserved), .cmd_done(cmd_done), .act_valid(act_valid), .act_kind(act_kind),
   .act_done(act_done), .operand_addr(operand_addr), .operand_valid(operand_valid),
   .xfer_send(xfer_send), .xfer_chain(xfer_chain), .xfer_padding(xfer_padding),
   .phase_change(phase_change), .bus_byte(bus_byte), .rx_store(rx_store));
